// >>> vdl_pkg.sv
// Constants shared by the video DAC and level DAC control block
package vdl_pkg;

  // ----------------------------------------------------------------
  // Parameter link addressing: category and byte number
  // ----------------------------------------------------------------
  localparam logic [4:0] VDL_CAT_SYSCON   = 5'h01;  // General system settings
  localparam logic [4:0] VDL_CAT_TG       = 5'h06;  // Timing generator settings
  localparam logic [4:0] VDL_CAT_LEVEL    = 5'h08;  // Level DAC settings
  localparam logic [4:0] VDL_CAT_CPU      = 5'h0C;  // Built-in controller settings
  localparam logic [4:0] VDL_CAT_EXPO     = 5'h0E;  // Exposure settings, set 2

  localparam logic [4:0] VDL_BYTE_OUT_CFG = 5'h03;  // analog_output_config
  localparam logic [4:0] VDL_BYTE_CLK_POL = 5'h13;  // sensor_clock_polarity (byte 19)
  localparam logic [4:0] VDL_BYTE_STANDBY = 5'h02;  // level_dac_standby
  localparam logic [4:0] VDL_BYTE_CH0     = 5'h03;  // level_dac_ch0_value
  localparam logic [4:0] VDL_BYTE_CH1     = 5'h04;  // level_dac_ch1_value
  localparam logic [4:0] VDL_BYTE_CH2     = 5'h05;  // level_dac_ch2_value
  localparam logic [4:0] VDL_BYTE_CPU     = 5'h05;  // cpu_control_flags
  localparam logic [4:0] VDL_BYTE_EXPO    = 5'h01;  // exposure_config_flags

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int VDL_VIDEO_OUT_SEL_BIT = 2;  // 0 mixed, 1 separated
  localparam int VDL_HCLK_A_INV_BIT    = 0;
  localparam int VDL_HCLK_B_INV_BIT    = 1;
  localparam int VDL_RG_INV_BIT        = 2;
  localparam int VDL_CH0_STB_BIT       = 5;  // Channels 1 and 2 follow upward
  localparam int VDL_EXPOSURE_HOLD_BIT = 2;
  localparam int VDL_IRIS_ENABLE_BIT   = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] VDL_RST_OUT_CFG = 8'h00;
  localparam logic [7:0] VDL_RST_CLK_POL = 8'h00;
  localparam logic [7:0] VDL_RST_STANDBY = 8'h00;
  localparam logic [7:0] VDL_RST_CODE    = 8'h00;
  localparam logic [7:0] VDL_RST_CPU     = 8'h00;
  localparam logic [7:0] VDL_RST_EXPO    = 8'h00;

  // ----------------------------------------------------------------
  // Video sample limits
  // ----------------------------------------------------------------
  localparam logic signed [11:0] VDL_MIX_MAX = 12'sh3FF;  // Top of 10-bit DAC
  localparam logic [9:0]         VDL_IDLE    = 10'h000;   // Unused DAC code

  // Analog output format
  typedef enum logic {VDL_MODE_MIXED, VDL_MODE_SEPARATE} vdl_mode_t;

endpackage

// >>> vdl_level_channel.sv
// One level DAC channel: stored code, ownership and standby
module vdl_level_channel
  import vdl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       host_wr_i,     // Host writes this channel's code
  input  wire logic [7:0] host_code_i,
  input  wire logic       auto_own_i,    // Automatic loop owns the channel
  input  wire logic       auto_valid_i,  // Automatic loop has a new code
  input  wire logic [7:0] auto_code_i,
  input  wire logic       standby_i,     // 1 stops conversion
  output logic      [7:0] code_o,        // Stored code, for readback
  output logic      [7:0] level_o,       // Code presented to the converter
  output logic            active_o       // Converter running
);

  // ----------------------------------------------------------------
  // Stored code and converter drive
  // ----------------------------------------------------------------
  logic [7:0] code_reg,  code_next;
  logic [7:0] level_reg, level_next;
  logic       act_reg,   act_next;

  // Next values; automatic update wins a same-cycle host write
  always_comb begin
    code_next  = code_reg;
    level_next = level_reg;
    if (auto_own_i && auto_valid_i) begin
      code_next = auto_code_i;
    end else if (host_wr_i) begin
      code_next = host_code_i;
    end
    // Standby freezes the drive but never touches the stored code
    if (!standby_i) begin
      level_next = code_reg;
    end
    act_next = !standby_i;
  end

  // Registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_reg  <= VDL_RST_CODE;
      level_reg <= VDL_RST_CODE;
      act_reg   <= 1'b0;
    end else begin
      code_reg  <= code_next;
      level_reg <= level_next;
      act_reg   <= act_next;
    end
  end

  assign code_o   = code_reg;
  assign level_o  = level_reg;
  assign active_o = act_reg;

endmodule // vdl_level_channel

// >>> vdl_video_level_ctrl.sv
// Video DAC format, sensor clock polarity and level DAC control
//
// Overview of operation
// - Select bit picks mixed or separated output
// - Separated: luma and chroma on own outputs
// - Mixed: summed luma on luma output only
// - Digital video only under internal sync
// - Three bits invert the three sensor clocks
// - Three independent eight-bit level DAC channels
// - Each channel coded by own byte; ch0 auto until hold bit set
// - Ch1 outputs user code unless iris loop on; ch2 user code
// - Channel 2 takes user code directly
// - Per-channel standby bit stops conversion
module vdl_video_level_ctrl
  import vdl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Parameter link, already decoded to category and byte
  input  wire logic       param_wr_i,
  input  wire logic [4:0] param_cat_i,
  input  wire logic [4:0] param_byte_i,
  input  wire logic [7:0] param_wdata_i,
  output logic      [7:0] param_rdata_o,
  // Video samples from the encoder
  input  wire logic [9:0] luma_i,
  input  wire logic [9:0] chroma_i,
  input  wire logic       int_sync_active_i,
  input  wire logic       digital_out_req_i,
  output logic            digital_out_en_o,
  output logic      [9:0] luma_current_out_o,
  output logic      [9:0] chroma_current_out_o,
  output logic            chroma_out_active_o,
  output logic            combined_luma_chroma_mode_o,
  // Sensor clocks from the timing generator
  input  wire logic       horiz_clk_a_i,
  input  wire logic       horiz_clk_b_i,
  input  wire logic       reset_gate_clk_i,
  output logic            horiz_clk_a_o,
  output logic            horiz_clk_b_o,
  output logic            reset_gate_clk_o,
  // Automatic loops
  input  wire logic       ae_gain_valid_i,
  input  wire logic [7:0] ae_gain_code_i,
  input  wire logic       iris_valid_i,
  input  wire logic [7:0] iris_code_i,
  // Level DAC channels
  output logic      [7:0] level_dac_ch0_o,
  output logic      [7:0] level_dac_ch1_o,
  output logic      [7:0] level_dac_ch2_o,
  output logic      [2:0] level_dac_active_o
);

  // ----------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------
  logic [7:0] out_cfg_reg, out_cfg_next;   // analog_output_config
  logic [7:0] clk_pol_reg, clk_pol_next;   // sensor_clock_polarity
  logic [7:0] standby_reg, standby_next;   // level_dac_standby
  logic [7:0] cpu_reg,     cpu_next;       // cpu_control_flags
  logic [7:0] expo_reg,    expo_next;      // exposure_config_flags
  logic [7:0] rdata_reg,   rdata_next;     // Readback of addressed byte
  logic       wr_ch0, wr_ch1, wr_ch2;      // Channel code write strobes
  logic [7:0] code0, code1, code2;         // Stored channel codes

  // Address decode for the channel codes
  assign wr_ch0 = param_wr_i && (param_cat_i == VDL_CAT_LEVEL) && (param_byte_i == VDL_BYTE_CH0);
  assign wr_ch1 = param_wr_i && (param_cat_i == VDL_CAT_LEVEL) && (param_byte_i == VDL_BYTE_CH1);
  assign wr_ch2 = param_wr_i && (param_cat_i == VDL_CAT_LEVEL) && (param_byte_i == VDL_BYTE_CH2);

  // Next values of the parameter bytes and the readback
  always_comb begin
    out_cfg_next = out_cfg_reg;
    clk_pol_next = clk_pol_reg;
    standby_next = standby_reg;
    cpu_next     = cpu_reg;
    expo_next    = expo_reg;
    if (param_wr_i) begin
      case ({param_cat_i, param_byte_i})
        {VDL_CAT_SYSCON, VDL_BYTE_OUT_CFG}: out_cfg_next = param_wdata_i;
        {VDL_CAT_TG,     VDL_BYTE_CLK_POL}: clk_pol_next = param_wdata_i;
        {VDL_CAT_LEVEL,  VDL_BYTE_STANDBY}: standby_next = param_wdata_i;
        {VDL_CAT_CPU,    VDL_BYTE_CPU}:     cpu_next     = param_wdata_i;
        {VDL_CAT_EXPO,   VDL_BYTE_EXPO}:    expo_next    = param_wdata_i;
        default: ;  // Codes go to the channels, other bytes ignored
      endcase
    end
    // Unmapped bytes read as zero; codes show automatic updates too
    case ({param_cat_i, param_byte_i})
      {VDL_CAT_SYSCON, VDL_BYTE_OUT_CFG}: rdata_next = out_cfg_reg;
      {VDL_CAT_TG,     VDL_BYTE_CLK_POL}: rdata_next = clk_pol_reg;
      {VDL_CAT_LEVEL,  VDL_BYTE_STANDBY}: rdata_next = standby_reg;
      {VDL_CAT_LEVEL,  VDL_BYTE_CH0}:     rdata_next = code0;
      {VDL_CAT_LEVEL,  VDL_BYTE_CH1}:     rdata_next = code1;
      {VDL_CAT_LEVEL,  VDL_BYTE_CH2}:     rdata_next = code2;
      {VDL_CAT_CPU,    VDL_BYTE_CPU}:     rdata_next = cpu_reg;
      {VDL_CAT_EXPO,   VDL_BYTE_EXPO}:    rdata_next = expo_reg;
      default:                            rdata_next = 8'h00;
    endcase
  end

  // Parameter registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_cfg_reg <= VDL_RST_OUT_CFG;
      clk_pol_reg <= VDL_RST_CLK_POL;
      standby_reg <= VDL_RST_STANDBY;
      cpu_reg     <= VDL_RST_CPU;
      expo_reg    <= VDL_RST_EXPO;
      rdata_reg   <= 8'h00;
    end else begin
      out_cfg_reg <= out_cfg_next;
      clk_pol_reg <= clk_pol_next;
      standby_reg <= standby_next;
      cpu_reg     <= cpu_next;
      expo_reg    <= expo_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign param_rdata_o = rdata_reg;

  // ----------------------------------------------------------------
  // Video DAC and sensor clock outputs
  // ----------------------------------------------------------------
  vdl_mode_t         mode;                 // Current analog format
  logic signed [11:0] mix_sum;             // Luma plus signed chroma
  logic [9:0]        mix_clamped;          // Sum limited to DAC range
  logic [9:0]        chroma_unsigned;      // Chroma offset to mid-scale
  logic [9:0]        luma_reg,   luma_next;
  logic [9:0]        chroma_reg, chroma_next;
  logic              c_act_reg,  c_act_next;
  logic              mix_reg,    mix_next;
  logic              dig_reg,    dig_next;
  logic [2:0]        hclk_reg,   hclk_next;
  logic [2:0]        hclk_want;            // Expected clock levels

  assign mode = out_cfg_reg[VDL_VIDEO_OUT_SEL_BIT] ? VDL_MODE_SEPARATE : VDL_MODE_MIXED;
  assign mix_sum = $signed({2'b00, luma_i}) + $signed({{2{chroma_i[9]}}, chroma_i});
  assign chroma_unsigned = {~chroma_i[9], chroma_i[8:0]};
  assign hclk_want = {reset_gate_clk_i ^ clk_pol_reg[VDL_RG_INV_BIT],
                      horiz_clk_b_i ^ clk_pol_reg[VDL_HCLK_B_INV_BIT],
                      horiz_clk_a_i ^ clk_pol_reg[VDL_HCLK_A_INV_BIT]};

  // Clamp keeps overshoot from wrapping into a dark sample
  always_comb begin
    if (mix_sum < 12'sh000) begin
      mix_clamped = 10'h000;
    end else if (mix_sum > VDL_MIX_MAX) begin
      mix_clamped = VDL_MIX_MAX[9:0];
    end else begin
      mix_clamped = mix_sum[9:0];
    end
  end

  // Next output values
  always_comb begin
    case (mode)
      VDL_MODE_SEPARATE: begin
        luma_next   = luma_i;
        chroma_next = chroma_unsigned;
        c_act_next  = 1'b1;
        mix_next    = 1'b0;
      end
      default: begin
        luma_next   = mix_clamped;
        chroma_next = VDL_IDLE;
        c_act_next  = 1'b0;
        mix_next    = 1'b1;
      end
    endcase
    // Analog output keeps running alongside digital output
    dig_next  = digital_out_req_i && int_sync_active_i;
    hclk_next = hclk_want;
  end

  // Output registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      luma_reg   <= VDL_IDLE;
      chroma_reg <= VDL_IDLE;
      c_act_reg  <= 1'b0;
      mix_reg    <= 1'b1;
      dig_reg    <= 1'b0;
      hclk_reg   <= 3'h0;
    end else begin
      luma_reg   <= luma_next;
      chroma_reg <= chroma_next;
      c_act_reg  <= c_act_next;
      mix_reg    <= mix_next;
      dig_reg    <= dig_next;
      hclk_reg   <= hclk_next;
    end
  end

  assign luma_current_out_o          = luma_reg;
  assign chroma_current_out_o        = chroma_reg;
  assign chroma_out_active_o         = c_act_reg;
  assign combined_luma_chroma_mode_o = mix_reg;
  assign digital_out_en_o            = dig_reg;
  assign horiz_clk_a_o               = hclk_reg[0];
  assign horiz_clk_b_o               = hclk_reg[1];
  assign reset_gate_clk_o            = hclk_reg[2];

  // ----------------------------------------------------------------
  // Level DAC channels
  // ----------------------------------------------------------------
  // Ch0 belongs to exposure control until the host sets the hold bit
  vdl_level_channel u_ch0 (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .host_wr_i    (wr_ch0),
    .host_code_i  (param_wdata_i),
    .auto_own_i   (!cpu_reg[VDL_EXPOSURE_HOLD_BIT]),
    .auto_valid_i (ae_gain_valid_i),
    .auto_code_i  (ae_gain_code_i),
    .standby_i    (standby_reg[VDL_CH0_STB_BIT]),
    .code_o       (code0),
    .level_o      (level_dac_ch0_o),
    .active_o     (level_dac_active_o[0])
  );

  // Ch1 belongs to the iris loop while that loop is enabled
  vdl_level_channel u_ch1 (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .host_wr_i    (wr_ch1),
    .host_code_i  (param_wdata_i),
    .auto_own_i   (expo_reg[VDL_IRIS_ENABLE_BIT]),
    .auto_valid_i (iris_valid_i),
    .auto_code_i  (iris_code_i),
    .standby_i    (standby_reg[VDL_CH0_STB_BIT + 1]),
    .code_o       (code1),
    .level_o      (level_dac_ch1_o),
    .active_o     (level_dac_active_o[1])
  );

  // Ch2 has no owner: a write lands directly
  vdl_level_channel u_ch2 (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .host_wr_i    (wr_ch2),
    .host_code_i  (param_wdata_i),
    .auto_own_i   (1'b0),
    .auto_valid_i (1'b0),
    .auto_code_i  (8'h00),
    .standby_i    (standby_reg[VDL_CH0_STB_BIT + 2]),
    .code_o       (code2),
    .level_o      (level_dac_ch2_o),
    .active_o     (level_dac_active_o[2])
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic ch2_run;                               // Channel 2 out of standby
  assign ch2_run = !standby_reg[VDL_CH0_STB_BIT + 2];

  sequence s_ch2_write;
    wr_ch2 && ch2_run;
  endsequence

  sequence s_ch2_settled;
    ch2_run [*2];
  endsequence

  a_select_follows: assert property (mix_reg == (mode == VDL_MODE_MIXED) || $changed(mode))
    else $error("format flag disagrees with select bit");
  a_sep_luma_pass: assert property ((mode == VDL_MODE_SEPARATE) |=>
      luma_current_out_o == $past(luma_i) && chroma_out_active_o)
    else $error("separated luma not passed through");
  a_mixed_chroma_idle: assert property ((mode == VDL_MODE_MIXED) |=>
      chroma_current_out_o == VDL_IDLE && !chroma_out_active_o
      && luma_current_out_o == $past(mix_clamped))
    else $error("mixed mode chroma output not idle");
  a_digital_gate: assert property (digital_out_en_o |-> $past(int_sync_active_i))
    else $error("digital output without internal sync");
  a_clk_invert: assert property (##1 {reset_gate_clk_o, horiz_clk_b_o, horiz_clk_a_o}
      == $past({reset_gate_clk_i ^ clk_pol_reg[VDL_RG_INV_BIT],
                horiz_clk_b_i ^ clk_pol_reg[VDL_HCLK_B_INV_BIT],
                horiz_clk_a_i ^ clk_pol_reg[VDL_HCLK_A_INV_BIT]}))
    else $error("sensor clock polarity wrong");
  a_ch0_auto: assert property ((ae_gain_valid_i && !cpu_reg[VDL_EXPOSURE_HOLD_BIT])
      |=> code0 == $past(ae_gain_code_i))
    else $error("gain channel not following exposure loop");
  a_ch1_user: assert property ((wr_ch1 && !expo_reg[VDL_IRIS_ENABLE_BIT]) |=>
      code1 == $past(param_wdata_i))
    else $error("channel 1 user code not stored");
  a_ch2_direct: assert property (s_ch2_write ##0 s_ch2_settled
      |=> level_dac_ch2_o == $past(param_wdata_i, 2))
    else $error("channel 2 code not presented");
  a_standby_stops: assert property (standby_reg[VDL_CH0_STB_BIT] |=>
      !level_dac_active_o[0] && $stable(level_dac_ch0_o))
    else $error("channel 0 converting in standby");
  a_standby_keeps: assert property ($rose(standby_reg[VDL_CH0_STB_BIT + 1]) && !wr_ch1
      && !(iris_valid_i && expo_reg[VDL_IRIS_ENABLE_BIT]) |=> $stable(code1))
    else $error("standby disturbed stored code");

endmodule // vdl_video_level_ctrl

// >>> vdl_far_model.sv
// Behavioural far side: video amplifier inputs and front-end gain pin
module vdl_far_model (
  input  wire logic       clk_i,
  input  wire logic [9:0] luma_current_out_i,    // Luma or combined DAC code
  input  wire logic [9:0] chroma_current_out_i,  // Chroma DAC code
  input  wire logic [7:0] gain_pin_i,            // Front-end gain control level
  output logic      [9:0] amp_luma_o,            // What the amplifier took
  output logic      [9:0] amp_chroma_o,
  output logic      [7:0] gain_seen_o            // What the front end took
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Amplifier and gain input sampling
  // ----------------------------------------------------------------
  // Chroma pin is sampled in both wirings, so a stray mixed-mode current shows
  always_ff @(posedge clk_i) begin
    amp_luma_o   <= luma_current_out_i;
    amp_chroma_o <= chroma_current_out_i;
    gain_seen_o  <= gain_pin_i;
  end
endmodule // vdl_far_model

// >>> tb.sv
// Self-checking testbench for the video and level DAC control block
module tb
  import vdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int RST_CYC = 50;  // Long enough for the minimum reset width
  logic       clk_i, reset_n_i, wr_en, int_sync, dig_req, hca, hcb, rgc, ae_v, ir_v;
  logic [4:0] cat, byt;
  logic [7:0] wdata, rdata, ae_code, ir_code, ch0, ch1, ch2, gain_seen;
  logic [9:0] luma, chroma, y_out, c_out, amp_y, amp_c;
  logic       dig_en, c_act, mixed, hca_o, hcb_o, rgc_o;
  logic [2:0] active;
  int         error_cnt, n_checks;

  vdl_video_level_ctrl uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .param_wr_i(wr_en), .param_cat_i(cat),
    .param_byte_i(byt), .param_wdata_i(wdata), .param_rdata_o(rdata),
    .luma_i(luma), .chroma_i(chroma), .int_sync_active_i(int_sync),
    .digital_out_req_i(dig_req), .digital_out_en_o(dig_en),
    .luma_current_out_o(y_out), .chroma_current_out_o(c_out),
    .chroma_out_active_o(c_act), .combined_luma_chroma_mode_o(mixed),
    .horiz_clk_a_i(hca), .horiz_clk_b_i(hcb), .reset_gate_clk_i(rgc),
    .horiz_clk_a_o(hca_o), .horiz_clk_b_o(hcb_o), .reset_gate_clk_o(rgc_o),
    .ae_gain_valid_i(ae_v), .ae_gain_code_i(ae_code), .iris_valid_i(ir_v),
    .iris_code_i(ir_code), .level_dac_ch0_o(ch0), .level_dac_ch1_o(ch1),
    .level_dac_ch2_o(ch2), .level_dac_active_o(active));

  vdl_far_model far (
    .clk_i(clk_i), .luma_current_out_i(y_out), .chroma_current_out_i(c_out),
    .gain_pin_i(ch0), .amp_luma_o(amp_y), .amp_chroma_o(amp_c),
    .gain_seen_o(gain_seen));

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #200us;
    error_cnt++;
    $display("watchdog expired");
    test_done();
  end

  task automatic step();  // Inputs always move 1 ns after the edge
    @(posedge clk_i);
    #1;
  endtask

  task automatic settle();  // Waits three edges for the registered outputs
    repeat (3) step();
  endtask

  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Strobe is dropped for a full cycle so back-to-back calls never clash
  task automatic wr(input logic [4:0] c, input logic [4:0] b, input logic [7:0] d);
    cat = c;
    byt = b;
    wdata = d;
    wr_en = 1'b1;
    step();
    wr_en = 1'b0;
    step();
  endtask

  task automatic rd(input logic [4:0] c, input logic [4:0] b, input logic [7:0] e);
    cat = c;
    byt = b;
    step();
    chk("rdata", {2'b00, e}, {2'b00, rdata});
  endtask

  task automatic auto_pulse(input logic iris, input logic [7:0] code);
    ae_code = code;
    ir_code = code;
    if (iris) ir_v = 1'b1;
    else ae_v = 1'b1;
    step();
    ae_v = 1'b0;
    ir_v = 1'b0;
    step();
  endtask

  task automatic vid(input logic [9:0] l, input logic [9:0] c, input logic [9:0] ey,
                     input logic [9:0] ec);
    luma = l;
    chroma = c;
    step();
    chk("luma_out", ey, y_out);
    chk("chroma_out", ec, c_out);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    reset_n_i = 1'b0;
    repeat (RST_CYC) step();
    chk("mode_in_reset", 10'h001, {9'h000, mixed});
    chk("ch0_in_reset", 10'h000, {2'b00, ch0});
    reset_n_i = 1'b1;
    step();
    chk("active_after_reset", 10'h007, {7'h00, active});
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [4:0] cs [8];
    logic [4:0] bs [8];
    cs = '{VDL_CAT_SYSCON, VDL_CAT_TG, VDL_CAT_LEVEL, VDL_CAT_LEVEL, VDL_CAT_LEVEL,
           VDL_CAT_LEVEL, VDL_CAT_CPU, VDL_CAT_EXPO};
    bs = '{VDL_BYTE_OUT_CFG, VDL_BYTE_CLK_POL, VDL_BYTE_STANDBY, VDL_BYTE_CH0,
           VDL_BYTE_CH1, VDL_BYTE_CH2, VDL_BYTE_CPU, VDL_BYTE_EXPO};
    for (int i = 0; i < 8; i++) rd(cs[i], bs[i], 8'h00);
    for (int i = 0; i < 8; i++) wr(cs[i], bs[i], 8'h5A ^ 8'(i));
    for (int i = 0; i < 8; i++) rd(cs[i], bs[i], 8'h5A ^ 8'(i));
    wr(5'h02, 5'h03, 8'hFF);  // Unmapped place is ignored and reads 0
    rd(5'h02, 5'h03, 8'h00);
    for (int i = 0; i < 8; i++) wr(cs[i], bs[i], 8'h00);
    $display("test regs done");
  endtask

  task automatic t_video();
    wr(VDL_CAT_SYSCON, VDL_BYTE_OUT_CFG, 8'h00);
    settle();
    chk("mixed_flag", 10'h001, {9'h000, mixed});
    chk("chroma_active", 10'h000, {9'h000, c_act});
    vid(10'd100, 10'd50, 10'd150, 10'h000);
    vid(10'd1000, 10'd100, 10'h3FF, 10'h000);
    vid(10'd20, -10'sd50, 10'h000, 10'h000);
    step();
    chk("amp_chroma", 10'h000, amp_c);
    wr(VDL_CAT_SYSCON, VDL_BYTE_OUT_CFG, 8'h04);
    settle();
    chk("mixed_flag", 10'h000, {9'h000, mixed});
    chk("chroma_active", 10'h001, {9'h000, c_act});
    vid(10'd1000, 10'h032, 10'd1000, 10'h232);
    vid(10'd7, 10'h3CE, 10'd7, 10'h1CE);
    step();
    chk("amp_luma", 10'd7, amp_y);
    chk("amp_chroma", 10'h1CE, amp_c);
    $display("test video done");
  endtask

  task automatic t_digital();
    for (int i = 0; i < 4; i++) begin
      {dig_req, int_sync} = 2'(i);
      step();
      chk("digital_en", {9'h000, i == 3}, {9'h000, dig_en});
    end
    $display("test digital done");
  endtask

  task automatic t_clkpol();
    for (int p = 0; p < 8; p++) begin
      wr(VDL_CAT_TG, VDL_BYTE_CLK_POL, 8'(p));
      settle();
      for (int v = 0; v < 8; v++) begin
        {rgc, hcb, hca} = 3'(v);
        step();
        chk("clk_out", 10'(v ^ p), {7'h00, rgc_o, hcb_o, hca_o});
      end
    end
    wr(VDL_CAT_TG, VDL_BYTE_CLK_POL, 8'h00);
    $display("test clkpol done");
  endtask

  task automatic t_level();
    wr(VDL_CAT_LEVEL, VDL_BYTE_CH0, 8'h11);
    auto_pulse(1'b0, 8'h22);  // Auto loop still owns channel 0
    settle();
    chk("ch0_auto", 10'h022, {2'b00, ch0});
    chk("gain_seen", 10'h022, {2'b00, gain_seen});
    wr(VDL_CAT_CPU, VDL_BYTE_CPU, 8'h04);
    wr(VDL_CAT_LEVEL, VDL_BYTE_CH0, 8'h5A);
    auto_pulse(1'b0, 8'hA5);
    settle();
    chk("ch0_user", 10'h05A, {2'b00, ch0});
    wr(VDL_CAT_EXPO, VDL_BYTE_EXPO, 8'h02);
    auto_pulse(1'b1, 8'h33);
    settle();
    chk("ch1_iris", 10'h033, {2'b00, ch1});
    wr(VDL_CAT_EXPO, VDL_BYTE_EXPO, 8'h00);
    wr(VDL_CAT_LEVEL, VDL_BYTE_CH1, 8'hC3);
    auto_pulse(1'b1, 8'h44);
    settle();
    chk("ch1_user", 10'h0C3, {2'b00, ch1});
    wr(VDL_CAT_LEVEL, VDL_BYTE_CH2, 8'hFF);
    settle();
    chk("ch2_user", 10'h0FF, {2'b00, ch2});
    chk("ch0_kept", 10'h05A, {2'b00, ch0});
    $display("test level done");
  endtask

  task automatic t_standby();
    for (int n = 0; n < 3; n++) begin
      wr(VDL_CAT_LEVEL, VDL_BYTE_STANDBY, 8'h20 << n);
      settle();
      chk("active_one", 10'(~(3'b001 << n) & 3'h7), {7'h00, active});
    end
    wr(VDL_CAT_LEVEL, VDL_BYTE_STANDBY, 8'hE0);
    wr(VDL_CAT_LEVEL, VDL_BYTE_CH2, 8'h3C);
    settle();
    chk("active_all", 10'h000, {7'h00, active});
    chk("ch2_frozen", 10'h0FF, {2'b00, ch2});
    rd(VDL_CAT_LEVEL, VDL_BYTE_CH2, 8'h3C);
    wr(VDL_CAT_LEVEL, VDL_BYTE_STANDBY, 8'h00);
    settle();
    chk("active_back", 10'h007, {7'h00, active});
    chk("ch2_resumed", 10'h03C, {2'b00, ch2});
    chk("ch1_resumed", 10'h0C3, {2'b00, ch1});
    $display("test standby done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reset_n_i, wr_en, int_sync, dig_req, hca, hcb, rgc, ae_v, ir_v} = '0;
    {cat, byt, wdata, ae_code, ir_code, luma, chroma} = '0;
    error_cnt = 0;
    n_checks = 0;
    t_reset();
    t_regs();
    t_video();
    t_digital();
    t_clkpol();
    t_level();
    t_standby();
    test_done();
  end
endmodule // tb
